// >>> verilog/psg_bus_device.sv
/*
 sound chip end: bus control decode, address latch, sixteen register array,
 two parallel port data stores. assumes bus lines come from the host on
 another timing and are synchronised here; port pins arrive from outside.
*/
// Notes on behaviour
// - idle codes keep bus undriven
// - latch codes capture bus as address
// - write code stores bus to addressed register
// - read code drives addressed register out
// - host may tie upper line high
// - sixteen registers, address then data
// - host selects: idle, latch, idle
// - host writes: idle, data, write, idle
// - host reads: idle, read, sample, idle
// - port data stores use normal sequences
// - undriven input port pins read one
// - fixed grouping of register numbers
// - low nibble selects, high bits chip select
// - reset clears every register
`timescale 1ns/1ps
`default_nettype none
module psg_bus_device
   import psg_bus_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   psg_bus_if.dev          bus,
   input  wire logic [7:0] port_a_pins_i,
   input  wire logic [7:0] port_b_pins_i,
   output logic      [7:0] port_a_pins_o,
   output logic      [7:0] port_a_pins_oe_n_o,
   output logic      [7:0] port_b_pins_o,
   output logic      [7:0] port_b_pins_oe_n_o,
   output logic      [7:0] tone_fine_a_o,
   output logic      [7:0] noise_period_o,
   output logic      [7:0] mixer_enable_o,
   output logic      [3:0] reg_addr_o
);

   // ***************************************
   // input synchronisers
   // ***************************************
   // the eight bus bits cross with no handshake: this relies on the host
   // holding data and code steady for three cycles or more around each
   // change of code, so a torn sample never meets an active code
   logic [2:0]  ctl_s1_ff,  ctl_s2_ff;
   logic [7:0]  dat_s1_ff,  dat_s2_ff;
   logic [1:0]  xs_s1_ff,   xs_s2_ff;
   logic [7:0]  pa_s1_ff,   pa_s2_ff;
   logic [7:0]  pb_s1_ff,   pb_s2_ff;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl_s1_ff <= IDLE_CODE;
         ctl_s2_ff <= IDLE_CODE;
         dat_s1_ff <= REG_RESET;
         dat_s2_ff <= REG_RESET;
         xs_s1_ff  <= 2'h0;
         xs_s2_ff  <= 2'h0;
         pa_s1_ff  <= PIN_IDLE_LEVEL;
         pa_s2_ff  <= PIN_IDLE_LEVEL;
         pb_s1_ff  <= PIN_IDLE_LEVEL;
         pb_s2_ff  <= PIN_IDLE_LEVEL;
      end
      else
      begin
         ctl_s1_ff <= {bus.bus_direction_line, bus.bus_control_upper, bus.bus_control_lower};
         ctl_s2_ff <= ctl_s1_ff;
         dat_s1_ff <= bus.shared_data_address_bus;
         dat_s2_ff <= dat_s1_ff;
         xs_s1_ff  <= {bus.extra_select_high, bus.extra_select_low};
         xs_s2_ff  <= xs_s1_ff;
         pa_s1_ff  <= port_a_pins_i;
         pa_s2_ff  <= pa_s1_ff;
         pb_s1_ff  <= port_b_pins_i;
         pb_s2_ff  <= pb_s1_ff;
      end
   end

   // ***************************************
   // port read select
   // ***************************************
   // one choice serves both ports: an output port returns its store,
   // an input port returns what its pins show after the synchroniser
   function automatic logic [7:0] port_read(input logic       dir_out,
                                            input logic [7:0] pins,
                                            input logic [7:0] store);
      if (dir_out)
         port_read = store;
      else
         port_read = pins;
   endfunction

   // ***************************************
   // decode, address latch, register array
   // ***************************************
   logic [7:0]  regs_ff [REG_COUNT];
   logic [7:0]  nxt_regs [REG_COUNT];
   logic [3:0]  addr_ff,   nxt_addr;
   logic        oen_ff,    nxt_oen;
   logic [7:0]  rdata_ff,  nxt_rdata;
   bus_func_e   func;
   logic        cs_hit;
   logic [7:0]  rd_val;

   always_comb
   begin
      func      = decode_func(ctl_s2_ff);
      cs_hit    = (dat_s2_ff[7:4] == CS_HIGH_NIBBLE) &&
                  (xs_s2_ff == {CS_EXTRA_HIGH, CS_EXTRA_LOW});
      nxt_addr  = addr_ff;
      nxt_regs  = regs_ff;
      nxt_oen   = 1'b1;
      if (addr_ff == REG_PORT_A)
         rd_val = port_read(regs_ff[REG_MIXER][MIX_DIR_A_BIT], pa_s2_ff, regs_ff[REG_PORT_A]);
      else if (addr_ff == REG_PORT_B)
         rd_val = port_read(regs_ff[REG_MIXER][MIX_DIR_B_BIT], pb_s2_ff, regs_ff[REG_PORT_B]);
      else
         rd_val = regs_ff[addr_ff];
      nxt_rdata = rdata_ff;
      case (func)
         BUS_LATCH:
         begin
            // a capture whose chip select misses leaves the old address
            if (cs_hit)
               nxt_addr = dat_s2_ff[3:0];
         end
         BUS_WRITE:
         begin
            // repeated every cycle the code stands; the bus byte is steady
            nxt_regs[addr_ff] = dat_s2_ff;
         end
         BUS_READ:
         begin
            nxt_oen   = 1'b0;
            nxt_rdata = rd_val;
         end
         default:
         begin
            nxt_oen = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            regs_ff[i] <= REG_RESET;
         addr_ff  <= ADDR_RESET;
         // enable kept active low in its own flop: no gate after it
         oen_ff   <= 1'b1;
         rdata_ff <= REG_RESET;
      end
      else
      begin
         regs_ff  <= nxt_regs;
         addr_ff  <= nxt_addr;
         oen_ff   <= nxt_oen;
         rdata_ff <= nxt_rdata;
      end
   end

   // ***************************************
   // outputs, all from flip-flops
   // ***************************************
   logic [7:0] pa_oe_n_ff,  pb_oe_n_ff;
   logic [7:0] nxt_pa_oe_n, nxt_pb_oe_n;

   // direction follows the mixer value being written, so the pins turn
   // on the same edge as the direction bit lands
   always_comb
   begin
      nxt_pa_oe_n = {8{~nxt_regs[REG_MIXER][MIX_DIR_A_BIT]}};
      nxt_pb_oe_n = {8{~nxt_regs[REG_MIXER][MIX_DIR_B_BIT]}};
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pa_oe_n_ff <= PIN_IDLE_LEVEL;
         pb_oe_n_ff <= PIN_IDLE_LEVEL;
      end
      else
      begin
         pa_oe_n_ff <= nxt_pa_oe_n;
         pb_oe_n_ff <= nxt_pb_oe_n;
      end
   end

   assign bus.dev_bus_out     = rdata_ff;
   assign bus.dev_bus_oe_n    = oen_ff;
   assign port_a_pins_o       = regs_ff[REG_PORT_A];
   assign port_b_pins_o       = regs_ff[REG_PORT_B];
   assign port_a_pins_oe_n_o  = pa_oe_n_ff;
   assign port_b_pins_oe_n_o  = pb_oe_n_ff;
   assign tone_fine_a_o       = regs_ff[REG_TONE_FIRST];
   assign noise_period_o      = regs_ff[REG_NOISE];
   assign mixer_enable_o      = regs_ff[REG_MIXER];
   assign reg_addr_o          = addr_ff;

endmodule
`default_nettype wire

// >>> include/psg_bus_pkg.sv
/*
 package for the sound generator host bus: control codes, register numbers,
 chip select defaults and reset values. assumes nothing of its surroundings.
*/
`default_nettype none
package psg_bus_pkg;

   // ***************************************
   // bus control codes {direction, upper, lower}
   // ***************************************
   localparam logic [2:0] IDLE_CODE          = 3'h0;
   localparam logic [2:0] ALT_LATCH_CODE_A   = 3'h1;
   localparam logic [2:0] IDLE_CODE_B        = 3'h2;
   localparam logic [2:0] READ_CODE          = 3'h3;
   localparam logic [2:0] ALT_LATCH_CODE_B   = 3'h4;
   localparam logic [2:0] IDLE_CODE_C        = 3'h5;
   localparam logic [2:0] WRITE_CODE         = 3'h6;
   localparam logic [2:0] LATCH_ADDRESS_CODE = 3'h7;

   typedef enum logic [1:0] {BUS_IDLE, BUS_LATCH, BUS_WRITE, BUS_READ} bus_func_e;

   // ***************************************
   // register array layout
   // ***************************************
   localparam int         REG_COUNT      = 16;
   localparam logic [3:0] REG_TONE_FIRST = 4'h0;
   localparam logic [3:0] REG_TONE_LAST  = 4'h5;
   localparam logic [3:0] REG_NOISE      = 4'h6;
   localparam logic [3:0] REG_MIXER      = 4'h7;
   localparam logic [3:0] REG_AMP_FIRST  = 4'h8;
   localparam logic [3:0] REG_AMP_LAST   = 4'ha;
   localparam logic [3:0] REG_ENV_FIRST  = 4'hb;
   localparam logic [3:0] REG_ENV_LAST   = 4'hd;
   localparam logic [3:0] REG_PORT_A     = 4'he;
   localparam logic [3:0] REG_PORT_B     = 4'hf;
   localparam int         MIX_DIR_A_BIT  = 6;
   localparam int         MIX_DIR_B_BIT  = 7;

   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [3:0] ADDR_RESET     = 4'h0;
   localparam logic [7:0] PIN_IDLE_LEVEL = 8'hff;

   // chip select: high bus nibble plus two extra address lines
   localparam logic [3:0] CS_HIGH_NIBBLE = 4'h0;
   localparam logic       CS_EXTRA_HIGH  = 1'b0;
   localparam logic       CS_EXTRA_LOW   = 1'b1;

   function automatic bus_func_e decode_func(input logic [2:0] code);
      if (code == WRITE_CODE)
         decode_func = BUS_WRITE;
      else if (code == READ_CODE)
         decode_func = BUS_READ;
      else if (code == ALT_LATCH_CODE_A || code == ALT_LATCH_CODE_B || code == LATCH_ADDRESS_CODE)
         decode_func = BUS_LATCH;
      else
         decode_func = BUS_IDLE;
   endfunction

endpackage
`default_nettype wire

// >>> include/psg_bus_if.sv
/*
 interface joining the host end and the sound chip end: three control lines,
 shared bus as in/out/enable per end, two extra select lines.
 resolves the shared bus itself from the enables, the device end first.
*/
`timescale 1ns/1ps
`default_nettype none
interface psg_bus_if;
   logic       bus_direction_line;
   logic       bus_control_upper;
   logic       bus_control_lower;
   logic       extra_select_high;
   logic       extra_select_low;
   logic [7:0] host_bus_out;
   logic       host_bus_oe_n;
   logic [7:0] dev_bus_out;
   logic       dev_bus_oe_n;
   logic [7:0] shared_data_address_bus;

   // active low enables; pulled high when nobody drives
   assign shared_data_address_bus = !dev_bus_oe_n ? dev_bus_out :
                                    !host_bus_oe_n ? host_bus_out : 8'hff;

   modport host (output bus_direction_line, output bus_control_upper, output bus_control_lower,
                 output extra_select_high, output extra_select_low, output host_bus_out,
                 output host_bus_oe_n, input shared_data_address_bus);
   modport dev  (input bus_direction_line, input bus_control_upper, input bus_control_lower,
                 input extra_select_high, input extra_select_low, output dev_bus_out,
                 output dev_bus_oe_n, input shared_data_address_bus);
endinterface
`default_nettype wire

// >>> verilog/psg_bus_host.sv
/*
 host end: turns a write or read request into the idle/latch/idle,
 idle/data/write/idle or idle/read/sample/idle sequences. each phase lasts
 PHASE_CYCLES clocks so the device's synchronisers settle. assumes the
 device end on the same interface.
*/
`timescale 1ns/1ps
`default_nettype none
module psg_bus_host
   import psg_bus_pkg::*;
#(
   parameter int PHASE_CYCLES = 4
)
(
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   psg_bus_if.host         bus,
   input  wire logic       req_i,
   input  wire logic       req_write_i,
   input  wire logic [3:0] req_reg_i,
   input  wire logic [7:0] req_wdata_i,
   output logic            busy_o,
   output logic            done_o,
   output logic      [7:0] rdata_o
);

   typedef enum {ST_IDLE, ST_A_IDLE, ST_A_LATCH, ST_A_END, ST_D_IDLE, ST_D_XFER, ST_D_END} host_st_e;

   host_st_e   st_ff,    nxt_st;
   logic [7:0] cnt_ff,   nxt_cnt;
   logic       wr_ff,    nxt_wr;
   logic [3:0] reg_ff,   nxt_reg;
   logic [7:0] wd_ff,    nxt_wd;
   logic [7:0] rd_ff,    nxt_rd;
   logic [2:0] code_ff,  nxt_code;
   logic [7:0] out_ff,   nxt_out;
   logic       oen_ff,   nxt_oen;
   logic       done_ff,  nxt_done;
   logic       busy_ff,  nxt_busy;
   logic       last;

   // upper control line always high: only four codes are used
   always_comb
   begin
      last     = (cnt_ff == 8'(PHASE_CYCLES - 1));
      nxt_st   = st_ff;
      nxt_cnt  = last ? 8'h00 : cnt_ff + 8'h01;
      nxt_wr   = wr_ff;
      nxt_reg  = reg_ff;
      nxt_wd   = wd_ff;
      nxt_rd   = rd_ff;
      nxt_code = code_ff;
      nxt_out  = out_ff;
      nxt_oen  = oen_ff;
      nxt_done = 1'b0;
      case (st_ff)
         ST_IDLE:
         begin
            nxt_cnt  = 8'h00;
            nxt_code = IDLE_CODE_B;
            nxt_oen  = 1'b1;
            if (req_i)
            begin
               nxt_wr  = req_write_i;
               nxt_reg = req_reg_i;
               nxt_wd  = req_wdata_i;
               nxt_st  = ST_A_IDLE;
            end
         end
         ST_A_IDLE:
            if (last)
            begin
               nxt_out  = {CS_HIGH_NIBBLE, reg_ff};
               nxt_oen  = 1'b0;
               nxt_code = LATCH_ADDRESS_CODE;
               nxt_st   = ST_A_LATCH;
            end
         ST_A_LATCH:
            if (last)
            begin
               nxt_code = IDLE_CODE_B;
               nxt_st   = ST_A_END;
            end
         ST_A_END:
            if (last)
            begin
               nxt_oen = !wr_ff;
               nxt_out = wd_ff;
               nxt_st  = ST_D_IDLE;
            end
         ST_D_IDLE:
            if (last)
            begin
               nxt_code = wr_ff ? WRITE_CODE : READ_CODE;
               nxt_st   = ST_D_XFER;
            end
         ST_D_XFER:
            if (last)
            begin
               if (!wr_ff)
                  nxt_rd = bus.shared_data_address_bus;
               nxt_code = IDLE_CODE_B;
               nxt_st   = ST_D_END;
            end
         ST_D_END:
            if (last)
            begin
               nxt_oen  = 1'b1;
               nxt_done = 1'b1;
               nxt_st   = ST_IDLE;
            end
         default:
            nxt_st = ST_IDLE;
      endcase
      nxt_busy = (nxt_st != ST_IDLE);
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_ff   <= ST_IDLE;
         cnt_ff  <= 8'h00;
         wr_ff   <= 1'b0;
         reg_ff  <= 4'h0;
         wd_ff   <= 8'h00;
         rd_ff   <= 8'h00;
         code_ff <= IDLE_CODE_B;
         out_ff  <= 8'h00;
         oen_ff  <= 1'b1;
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         wr_ff   <= nxt_wr;
         reg_ff  <= nxt_reg;
         wd_ff   <= nxt_wd;
         rd_ff   <= nxt_rd;
         code_ff <= nxt_code;
         out_ff  <= nxt_out;
         oen_ff  <= nxt_oen;
         done_ff <= nxt_done;
         busy_ff <= nxt_busy;
      end
   end

   assign bus.bus_direction_line = code_ff[2];
   assign bus.bus_control_upper  = code_ff[1];
   assign bus.bus_control_lower  = code_ff[0];
   assign bus.extra_select_high  = CS_EXTRA_HIGH;
   assign bus.extra_select_low   = CS_EXTRA_LOW;
   assign bus.host_bus_out       = out_ff;
   assign bus.host_bus_oe_n      = oen_ff;
   assign busy_o                 = busy_ff;
   assign done_o                 = done_ff;
   assign rdata_o                = rd_ff;

endmodule
`default_nettype wire

// >>> bench/psg_bus_assertions.sv
/*
 concurrent checks on the bus between the host end and the sound chip end.
 assumes one clock domain and the interface signals wired in by name.
*/
`timescale 1ns/1ps
`default_nettype none
module psg_bus_assertions
   import psg_bus_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   input  wire logic       bus_direction_line,
   input  wire logic       bus_control_upper,
   input  wire logic       bus_control_lower,
   input  wire logic       extra_select_high,
   input  wire logic       extra_select_low,
   input  wire logic [7:0] host_bus_out,
   input  wire logic       host_bus_oe_n,
   input  wire logic [7:0] dev_bus_out,
   input  wire logic       dev_bus_oe_n,
   input  wire logic [7:0] shared_data_address_bus
);
   logic [2:0] code;
   logic       rd;
   logic       wr;
   logic       lat;
   logic       idl;

   assign code = {bus_direction_line, bus_control_upper, bus_control_lower};
   assign rd   = code == READ_CODE;
   assign wr   = code == WRITE_CODE;
   assign lat  = code == LATCH_ADDRESS_CODE;
   assign idl  = code == IDLE_CODE_B;

   default clocking dc @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   // ***************************************
   // read answer
   // ***************************************
   // the device samples through a two-flop synchroniser, so answers lag
   sequence read_held;
      rd [*4];
   endsequence
   sequence drive_answer;
      ##[0:1] !dev_bus_oe_n;
   endsequence
   sequence idle_run;
      idl [*5];
   endsequence

   read_answer_a: assert property (read_held |-> drive_answer)
      else $error("device did not drive during read");
   drive_cause_a: assert property (!dev_bus_oe_n |->
      $past(rd, 1) || $past(rd, 2) || $past(rd, 3) || $past(rd, 4) || $past(rd, 5))
      else $error("device drove without a read");
   idle_float_a: assert property (idle_run |-> dev_bus_oe_n)
      else $error("device drove during idle");
   no_clash_a: assert property (!(!host_bus_oe_n && !dev_bus_oe_n))
      else $error("both ends drive the bus");

   // ***************************************
   // host sequences
   // ***************************************
   upper_high_a: assert property (bus_control_upper)
      else $error("upper control line not high");
   entry_idle_a: assert property ($changed(code) && !idl |-> $past(idl))
      else $error("active code not entered from idle");
   chip_select_a: assert property (lat && $past(lat) |-> !host_bus_oe_n
      && extra_select_high == CS_EXTRA_HIGH && extra_select_low == CS_EXTRA_LOW
      && shared_data_address_bus[7:4] == CS_HIGH_NIBBLE)
      else $error("address phase without chip select");
   write_data_a: assert property (wr && $past(wr) |-> !host_bus_oe_n && $stable(host_bus_out))
      else $error("write data not held");

   read_seen_c: cover property (read_held);
endmodule
`default_nettype wire

// >>> bench/sound_chip_bus_interface_tb_top.sv
/*
 testbench: host end and sound chip end joined by the interface; the bench
 drives host requests and port pins. assumes pull-ups on idle port pins.
*/
`timescale 1ns/1ps
`default_nettype none
module sound_chip_bus_interface_tb_top
   import psg_bus_pkg::*;
;
   logic       clk_sys_i;
   logic       arst_n_i;
   logic       req_i;
   logic       req_write_i;
   logic [3:0] req_reg_i;
   logic [7:0] req_wdata_i;
   logic       busy_o;
   logic       done_o;
   logic [7:0] rdata_o;
   logic [7:0] ext_a;
   logic [7:0] ext_b;
   logic [7:0] port_a_pins_i;
   logic [7:0] port_b_pins_i;
   logic [7:0] port_a_pins_o;
   logic [7:0] port_a_pins_oe_n_o;
   logic [7:0] port_b_pins_o;
   logic [7:0] port_b_pins_oe_n_o;
   logic [7:0] tone_fine_a_o;
   logic [7:0] noise_period_o;
   logic [7:0] mixer_enable_o;
   logic [3:0] reg_addr_o;
   logic [7:0] d;
   int         fails;
   int         n_compared;

   // pins not driven by the device follow the outside level (pull-up = ff)
   assign port_a_pins_i = (port_a_pins_o & ~port_a_pins_oe_n_o) | (ext_a & port_a_pins_oe_n_o);
   assign port_b_pins_i = (port_b_pins_o & ~port_b_pins_oe_n_o) | (ext_b & port_b_pins_oe_n_o);

   psg_bus_if u_psg_bus_if ();
   psg_bus_host #(.PHASE_CYCLES(4)) u_psg_bus_host (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .bus(u_psg_bus_if), .req_i(req_i), .req_write_i(req_write_i), .req_reg_i(req_reg_i),
      .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
   psg_bus_device u_psg_bus_device (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(u_psg_bus_if),
      .port_a_pins_i(port_a_pins_i), .port_b_pins_i(port_b_pins_i), .port_a_pins_o(port_a_pins_o),
      .port_a_pins_oe_n_o(port_a_pins_oe_n_o), .port_b_pins_o(port_b_pins_o),
      .port_b_pins_oe_n_o(port_b_pins_oe_n_o), .tone_fine_a_o(tone_fine_a_o),
      .noise_period_o(noise_period_o), .mixer_enable_o(mixer_enable_o), .reg_addr_o(reg_addr_o));
   psg_bus_assertions u_psg_bus_assertions (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .bus_direction_line(u_psg_bus_if.bus_direction_line), .bus_control_upper(u_psg_bus_if.bus_control_upper),
      .bus_control_lower(u_psg_bus_if.bus_control_lower), .extra_select_high(u_psg_bus_if.extra_select_high),
      .extra_select_low(u_psg_bus_if.extra_select_low), .host_bus_out(u_psg_bus_if.host_bus_out),
      .host_bus_oe_n(u_psg_bus_if.host_bus_oe_n), .dev_bus_out(u_psg_bus_if.dev_bus_out),
      .dev_bus_oe_n(u_psg_bus_if.dev_bus_oe_n), .shared_data_address_bus(u_psg_bus_if.shared_data_address_bus));

   // ***************************************
   // shared tasks
   // ***************************************
   function automatic logic [7:0] pat(input logic [3:0] i);
      return {~i, i};
   endfunction

   task automatic check_value(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic access(input logic wr, input logic [3:0] rg, input logic [7:0] wd, output logic [7:0] rd);
      int k;
      @(negedge clk_sys_i);
      req_i       = 1'b1;
      req_write_i = wr;
      req_reg_i   = rg;
      req_wdata_i = wd;
      @(negedge clk_sys_i);
      req_i = 1'b0;
      k     = 0;
      check_value({7'h00, busy_o}, 8'h01);
      while (done_o !== 1'b1 && k < 80)
      begin
         @(negedge clk_sys_i);
         k++;
      end
      if (k == 80)
      begin
         fails++;
         $display("BAD t=%0t no done from host", $time);
      end
      check_value({7'h00, busy_o}, 8'h00);
      rd = rdata_o;
   endtask

   task automatic write_reg(input logic [3:0] rg, input logic [7:0] wd);
      logic [7:0] x;
      access(1'b1, rg, wd, x);
   endtask

   task automatic read_reg(input logic [3:0] rg, output logic [7:0] rd);
      access(1'b0, rg, 8'h00, rd);
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset;
      arst_n_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      check_value(tone_fine_a_o, REG_RESET);
      check_value(noise_period_o, REG_RESET);
      check_value(mixer_enable_o, REG_RESET);
      check_value(port_a_pins_o, REG_RESET);
      check_value({4'h0, reg_addr_o}, {4'h0, ADDR_RESET});
      check_value(port_b_pins_oe_n_o, PIN_IDLE_LEVEL);
      read_reg(REG_ENV_LAST, d);
      check_value(d, REG_RESET);
   endtask

   task automatic t_array;
      for (int i = 0; i < 14; i++)
      begin
         write_reg(i[3:0], pat(i[3:0]));
         check_value({4'h0, reg_addr_o}, {4'h0, i[3:0]});
      end
      for (int i = 13; i >= 0; i--)
      begin
         read_reg(i[3:0], d);
         check_value(d, pat(i[3:0]));
      end
      check_value(tone_fine_a_o, pat(REG_TONE_FIRST));
      check_value(noise_period_o, pat(REG_NOISE));
      check_value(mixer_enable_o, pat(REG_MIXER));
   endtask

   task automatic t_ports;
      ext_a = 8'h5a;
      ext_b = 8'hff;
      write_reg(REG_MIXER, 8'h00);
      check_value(port_a_pins_oe_n_o, 8'hff);
      write_reg(REG_PORT_A, 8'h3c);
      check_value(port_a_pins_o, 8'h3c);
      read_reg(REG_PORT_A, d);
      check_value(d, 8'h5a);
      read_reg(REG_PORT_B, d);
      check_value(d, 8'hff);
      write_reg(REG_MIXER, 8'h40);
      check_value(port_a_pins_oe_n_o, 8'h00);
      check_value(port_b_pins_oe_n_o, 8'hff);
      read_reg(REG_PORT_A, d);
      check_value(d, 8'h3c);
      write_reg(REG_PORT_B, 8'h96);
      check_value(port_b_pins_o, 8'h96);
      write_reg(REG_MIXER, 8'hc0);
      read_reg(REG_PORT_B, d);
      check_value(d, 8'h96);
   endtask

   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // whole run needs about a thousand cycles; this limit is far beyond it
   initial
   begin
      #200000;
      fails++;
      $display("BAD t=%0t run did not finish", $time);
      complete_run();
   end

   initial
   begin
      fails       = 0;
      n_compared  = 0;
      req_i       = 1'b0;
      req_write_i = 1'b0;
      req_reg_i   = 4'h0;
      req_wdata_i = 8'h00;
      ext_a       = 8'hff;
      ext_b       = 8'hff;
      t_reset();
      t_array();
      t_ports();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire
